// file: logic/quasi_port_pkg.sv
package quasi_port_pkg;

  // ----------------------------------------------------------------
  // port geometry and reset values
  // ----------------------------------------------------------------
  localparam int          PORT_W       = 8;        // bits in each port
  localparam logic [7:0]  LATCH_RST    = 8'hff;    // every latch bit comes up at 1
  localparam logic [7:0]  ALL_ONES     = 8'hff;    // neutral alternate value
  localparam logic [7:0]  ALL_ZEROS    = 8'h00;    // nothing forced

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 10;      // ref_clk period
  localparam int          STRONG_HI_NS  = 20;      // transition driver on-time
  // least on-time, rounded up to whole cycles, never below one
  localparam int          STRONG_HI_CYC = (STRONG_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                          (STRONG_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STRAP_WAIT    = 2;       // cycles before strap sample is trusted

  // ----------------------------------------------------------------
  // port 1 alternate bit positions
  // ----------------------------------------------------------------
  localparam int P1_TIMER2_IO  = 0;
  localparam int P1_TIMER2_TRG = 1;
  localparam int P1_SER1_RX    = 2;
  localparam int P1_SER1_TX    = 3;
  localparam int P1_IRQ2       = 4;
  localparam int P1_IRQ3       = 5;
  localparam int P1_IRQ4       = 6;
  localparam int P1_IRQ5       = 7;

  // ----------------------------------------------------------------
  // port 3 alternate bit positions
  // ----------------------------------------------------------------
  localparam int P3_SER0_RX = 0;
  localparam int P3_SER0_TX = 1;
  localparam int P3_IRQ0    = 2;
  localparam int P3_IRQ1    = 3;
  localparam int P3_TMR0    = 4;
  localparam int P3_TMR1    = 5;
  localparam int P3_WR_N    = 6;
  localparam int P3_RD_N    = 7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // software store into a port latch
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } latch_write_type;

  // drive state of eight pins
  typedef struct packed {
    logic [7:0] out;   // level driven when oe is high
    logic [7:0] oe;    // strong driver active
    logic [7:0] pu;    // weak sustaining pull-up active
  } pin_drive_type;

endpackage

// file: logic/quasi_pin_bank.sv
`timescale 1ns/1ps

module quasi_pin_bank #(
  parameter int STRONG_CYC = quasi_port_pkg::STRONG_HI_CYC
) (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  // software latch store
  input  wire quasi_port_pkg::latch_write_type latch_wr,
  // alternate outputs, 1 where unused
  input  wire logic [7:0]                      alt_val,
  // strong drive of both levels (address bus)
  input  wire logic [7:0]                      force_en,
  input  wire logic [7:0]                      force_val,
  // pins
  input  wire logic [7:0]                      pin_in,
  output quasi_port_pkg::pin_drive_type        pins,
  // synchronised pin levels and latch contents
  output logic [7:0]                           pin_rd,
  output logic [7:0]                           latch_q
);

  // countdown is eight bits wide, so a longer pulse cannot be served
  if (STRONG_CYC < 1 || STRONG_CYC > 255) begin : g_bad_strong
    $error("quasi_pin_bank: STRONG_CYC out of range");
  end

  logic [7:0] drive_d;                 // level the pin should show
  logic [7:0] drive_q;                 // registered pin level
  logic [7:0] force_q;                 // registered forced-drive mask
  logic [7:0] strong_q [8];            // transition driver countdown
  logic [7:0] strong_on;               // countdown nonzero
  logic [7:0] sync1_q;                 // first synchroniser stage
  logic [7:0] sync2_q;                 // second synchroniser stage

  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  // software store; reset sets every bit to 1
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      latch_q <= quasi_port_pkg::LATCH_RST;
    end else if (latch_wr.wr) begin
      latch_q <= latch_wr.data;
    end
  end

  // alternate output only wins where the latch holds 1
  always_comb begin
    drive_d = (force_en & force_val) | (~force_en & latch_q & alt_val);
  end

  // ----------------------------------------------------------------
  // drive state
  // ----------------------------------------------------------------
  // registered level and forced mask
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive_q <= quasi_port_pkg::LATCH_RST;
      force_q <= quasi_port_pkg::ALL_ZEROS;
    end else begin
      drive_q <= drive_d;
      force_q <= force_en;
    end
  end

  // a 0 to 1 step loads the transition driver; it then counts down
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_n) begin
        strong_q[i] <= 8'h00;
      end else if (drive_d[i] && !drive_q[i]) begin
        strong_q[i] <= 8'(STRONG_CYC);
      end else if (strong_q[i] != 8'h00) begin
        strong_q[i] <= strong_q[i] - 8'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      strong_on[i] = (strong_q[i] != 8'h00);
    end
  end

  // low is always strong; high is strong only while pulsing or forced
  assign pins.out = drive_q;
  assign pins.oe  = ~drive_q | strong_on | force_q;
  assign pins.pu  = ~(~drive_q | strong_on | force_q);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // two stages before anything reads a pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_q <= quasi_port_pkg::ALL_ONES;
      sync2_q <= quasi_port_pkg::ALL_ONES;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign pin_rd = sync2_q;

endmodule

// file: logic/quasi_bidir_port_altfn.sv
`timescale 1ns/1ps

// Overview of operation
// - address port pins come up high, weak
// - third port latch resets to all ones
// - storing 0 turns on strong pull-down
// - 0 to 1 gives brief strong high
// - then weak pull-up: output high and input
// - address port drives upper address byte
// - port 1 timer2 and serial 1 lines
// - port 1 upper bits are edge interrupts
// - port 3 serial 0 and interrupts 0, 1
// - port 3 bits 4, 5 feed timers
// - port 3 carries write and read strobes
// - program source pin picks code memory
// - port 1 resets to ones, weak pull-ups

module quasi_bidir_port_altfn #(
  parameter int STRONG_CYC = quasi_port_pkg::STRONG_HI_CYC
) (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  // software latch stores
  input  wire quasi_port_pkg::latch_write_type p1_wr,
  input  wire quasi_port_pkg::latch_write_type p2_wr,
  input  wire quasi_port_pkg::latch_write_type p3_wr,
  // pin levels seen on the board
  input  wire logic [7:0]                      p1_pin_in,
  input  wire logic [7:0]                      p2_pin_in,
  input  wire logic [7:0]                      p3_pin_in,
  // pin drive state
  output quasi_port_pkg::pin_drive_type        p1_pins,
  output quasi_port_pkg::pin_drive_type        p2_pins,
  output quasi_port_pkg::pin_drive_type        p3_pins,
  // synchronised pin reads for software
  output logic [7:0]                           p1_rd,
  output logic [7:0]                           p2_rd,
  output logic [7:0]                           p3_rd,
  // external memory bus from the core
  input  wire logic                            addr_en,
  input  wire logic [7:0]                      addr_hi,
  input  wire logic                            wr_strobe_n,
  input  wire logic                            rd_strobe_n,
  // peripheral outputs from the core
  input  wire logic                            timer2_out,
  input  wire logic                            serial1_out,
  input  wire logic                            serial0_out,
  // peripheral inputs to the core
  output logic                                 timer2_ext_io,
  output logic                                 timer2_trigger_in,
  output logic                                 serial1_in,
  output logic                                 serial0_in,
  output logic                                 ext_irq_0,
  output logic                                 ext_irq_1,
  output logic                                 ext_irq_2_rise,
  output logic                                 ext_irq_3_fall,
  output logic                                 ext_irq_4_rise,
  output logic                                 ext_irq_5_fall,
  output logic                                 timer0_count_in,
  output logic                                 timer1_count_in,
  // program source strap
  input  wire logic                            program_source_sel_n,
  output logic                                 fetch_external_q
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] p1_alt;                  // port 1 alternate outputs
  logic [7:0] p3_alt;                  // port 3 alternate outputs
  logic [7:0] p1_latch;                // port 1 latch contents
  logic [7:0] p2_latch;                // port 2 latch contents
  logic [7:0] p3_latch;                // port 3 latch contents
  logic [7:0] p1_prev_q;               // previous synchronised port 1 level
  logic [3:0] irq_edge_q;              // registered edge pulses
  logic       strap_s1_q;              // strap first stage
  logic       strap_s2_q;              // strap second stage
  logic [1:0] strap_cnt_q;             // wait after reset release
  logic       strap_done_q;            // strap has been taken

  // edge detect on a sampled pin pair
  function automatic logic edge_of(input logic now, input logic was, input logic rising);
    edge_of = rising ? (now & ~was) : (~now & was);
  endfunction

  // ----------------------------------------------------------------
  // alternate output maps
  // ----------------------------------------------------------------
  // input-only alternate bits stay at 1 so the weak pull-up lets them be read
  always_comb begin
    p1_alt                             = quasi_port_pkg::ALL_ONES;
    p1_alt[quasi_port_pkg::P1_TIMER2_IO] = timer2_out;
    p1_alt[quasi_port_pkg::P1_SER1_TX]   = serial1_out;
  end

  always_comb begin
    p3_alt                             = quasi_port_pkg::ALL_ONES;
    p3_alt[quasi_port_pkg::P3_SER0_TX] = serial0_out;
    p3_alt[quasi_port_pkg::P3_WR_N]    = wr_strobe_n;
    p3_alt[quasi_port_pkg::P3_RD_N]    = rd_strobe_n;
  end

  // ----------------------------------------------------------------
  // port banks
  // ----------------------------------------------------------------
  // port 1: timer 2, serial 1, edge interrupts
  quasi_pin_bank #(
    .STRONG_CYC (STRONG_CYC)
  ) u_port1 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .latch_wr  (p1_wr),
    .alt_val   (p1_alt),
    .force_en  (quasi_port_pkg::ALL_ZEROS),
    .force_val (quasi_port_pkg::ALL_ZEROS),
    .pin_in    (p1_pin_in),
    .pins      (p1_pins),
    .pin_rd    (p1_rd),
    .latch_q   (p1_latch)
  );

  // port 2: upper address byte drives both levels hard while the bus owns it
  quasi_pin_bank #(
    .STRONG_CYC (STRONG_CYC)
  ) u_port2 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .latch_wr  (p2_wr),
    .alt_val   (quasi_port_pkg::ALL_ONES),
    .force_en  ({8{addr_en}}),
    .force_val (addr_hi),
    .pin_in    (p2_pin_in),
    .pins      (p2_pins),
    .pin_rd    (p2_rd),
    .latch_q   (p2_latch)
  );

  // port 3: serial 0, interrupts, timers, memory strobes
  quasi_pin_bank #(
    .STRONG_CYC (STRONG_CYC)
  ) u_port3 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .latch_wr  (p3_wr),
    .alt_val   (p3_alt),
    .force_en  (quasi_port_pkg::ALL_ZEROS),
    .force_val (quasi_port_pkg::ALL_ZEROS),
    .pin_in    (p3_pin_in),
    .pins      (p3_pins),
    .pin_rd    (p3_rd),
    .latch_q   (p3_latch)
  );

  // ----------------------------------------------------------------
  // alternate inputs
  // ----------------------------------------------------------------
  // level inputs come straight from the synchronised pin
  // two flops of delay: a pin pulse shorter than one cycle may be missed
  assign timer2_ext_io     = p1_rd[quasi_port_pkg::P1_TIMER2_IO];
  assign timer2_trigger_in = p1_rd[quasi_port_pkg::P1_TIMER2_TRG];
  assign serial1_in        = p1_rd[quasi_port_pkg::P1_SER1_RX];
  assign serial0_in        = p3_rd[quasi_port_pkg::P3_SER0_RX];
  assign ext_irq_0         = p3_rd[quasi_port_pkg::P3_IRQ0];
  assign ext_irq_1         = p3_rd[quasi_port_pkg::P3_IRQ1];
  assign timer0_count_in   = p3_rd[quasi_port_pkg::P3_TMR0];
  assign timer1_count_in   = p3_rd[quasi_port_pkg::P3_TMR1];

  // ----------------------------------------------------------------
  // edge interrupts
  // ----------------------------------------------------------------
  // one-cycle pulse per detected edge; the core keeps the flags
  // no clear enters here, so there is no set-against-clear race to settle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      p1_prev_q  <= quasi_port_pkg::ALL_ONES;
      irq_edge_q <= 4'h0;
    end else begin
      p1_prev_q     <= p1_rd;
      irq_edge_q[0] <= edge_of(p1_rd[quasi_port_pkg::P1_IRQ2], p1_prev_q[quasi_port_pkg::P1_IRQ2], 1'b1);
      irq_edge_q[1] <= edge_of(p1_rd[quasi_port_pkg::P1_IRQ3], p1_prev_q[quasi_port_pkg::P1_IRQ3], 1'b0);
      irq_edge_q[2] <= edge_of(p1_rd[quasi_port_pkg::P1_IRQ4], p1_prev_q[quasi_port_pkg::P1_IRQ4], 1'b1);
      irq_edge_q[3] <= edge_of(p1_rd[quasi_port_pkg::P1_IRQ5], p1_prev_q[quasi_port_pkg::P1_IRQ5], 1'b0);
    end
  end

  assign ext_irq_2_rise = irq_edge_q[0];
  assign ext_irq_3_fall = irq_edge_q[1];
  assign ext_irq_4_rise = irq_edge_q[2];
  assign ext_irq_5_fall = irq_edge_q[3];

  // ----------------------------------------------------------------
  // program source strap
  // ----------------------------------------------------------------
  // synchroniser for the strap pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_s1_q <= 1'b1;
      strap_s2_q <= 1'b1;
    end else begin
      strap_s1_q <= program_source_sel_n;
      strap_s2_q <= strap_s1_q;
    end
  end

  // taken once after release so a moving pin cannot switch code memory mid-run
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_cnt_q      <= 2'h0;
      strap_done_q     <= 1'b0;
      fetch_external_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == 2'(quasi_port_pkg::STRAP_WAIT)) begin
        fetch_external_q <= ~strap_s2_q;
        strap_done_q     <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_p2_reset_high: assert property (@(posedge ref_clk) !rst_n |=> (p2_pins.out == 8'hff && p2_pins.pu == 8'hff))
    else $error("port 2 not weak high after reset");

  a_p3_reset_ones: assert property (@(posedge ref_clk) !rst_n |=> (p3_latch == 8'hff && p3_pins.oe == 8'h00))
    else $error("port 3 latch not all ones after reset");

  a_p1_reset_ones: assert property (@(posedge ref_clk) !rst_n |=> (p1_latch == 8'hff && p1_pins.pu == 8'hff))
    else $error("port 1 not weak high after reset");

  a_zero_pulls_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (p1_wr.wr && !p1_wr.data[2]) |=> ##1 (p1_pins.oe[2] && !p1_pins.out[2]))
    else $error("stored zero did not pull pin down");

  a_strong_hi_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(p3_pins.out[5]) |-> p3_pins.oe[5] [*2])
    else $error("transition driver too short");

  a_weak_after_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(p3_pins.out[5]) ##2 p3_pins.out[5] |-> (!p3_pins.oe[5] && p3_pins.pu[5]))
    else $error("pin not back to weak pull-up");

  a_addr_byte_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
      addr_en |=> (p2_pins.out == $past(addr_hi) && p2_pins.oe == 8'hff))
    else $error("address byte not driven");

  a_ser1_tx_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !serial1_out |=> !p1_pins.out[3])
    else $error("serial 1 output not on pin");

  a_irq2_rising: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (p1_rd[4] && !p1_prev_q[4]) |=> ext_irq_2_rise)
    else $error("rising edge on interrupt 2 missed");

  a_irq3_falling: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ext_irq_3_fall |-> ($past(p1_prev_q[5]) && !$past(p1_rd[5])))
    else $error("interrupt 3 pulse without falling edge");

  a_wr_strobe_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!wr_strobe_n && p3_latch[6]) |=> (!p3_pins.out[6] && p3_pins.oe[6]))
    else $error("write strobe not on pin");

  a_strap_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
      strap_done_q |=> $stable(fetch_external_q))
    else $error("program source changed after capture");

  a_rd_strobe_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!rd_strobe_n && p3_latch[7]) |=> (!p3_pins.out[7] && p3_pins.oe[7]))
    else $error("read strobe not on pin");

  a_ser0_tx_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!serial0_out && p3_latch[1]) |=> !p3_pins.out[1])
    else $error("serial 0 output not on pin");

  a_latch_zero_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !p1_latch[3] |=> (!p1_pins.out[3] && p1_pins.oe[3]))
    else $error("alternate output overrode a zero latch");

  a_irq4_rising: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (p1_rd[6] && !p1_prev_q[6]) |=> ext_irq_4_rise)
    else $error("rising edge on interrupt 4 missed");

  a_irq5_falling: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!p1_rd[7] && p1_prev_q[7]) |=> ext_irq_5_fall)
    else $error("falling edge on interrupt 5 missed");

  a_irq_pulse_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ext_irq_2_rise |=> !ext_irq_2_rise)
    else $error("interrupt 2 pulse longer than one cycle");

  c_irq_fall:     cover property (@(posedge ref_clk) disable iff (!rst_n) ext_irq_5_fall);
  c_strong_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(p1_pins.out[0]));
  c_addr_cycle:   cover property (@(posedge ref_clk) disable iff (!rst_n) addr_en ##1 !addr_en);
  c_irq_rise:     cover property (@(posedge ref_clk) disable iff (!rst_n) ext_irq_4_rise);
  c_ext_fetch:    cover property (@(posedge ref_clk) disable iff (!rst_n) strap_done_q && fetch_external_q);

endmodule

// file: tb/pin_board_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// board side of one eight-pin port
// ----------------------------------------------------------------
module pin_board_model (
  // device drive state
  input  wire quasi_port_pkg::pin_drive_type pins,
  // external drivers on the board
  input  wire logic [7:0]                    ext_en,
  input  wire logic [7:0]                    ext_val,
  // resolved pin level
  output logic [7:0]                         level
);
  // strong device driver wins, board drivers beat the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pins.oe[i]) begin
        level[i] = pins.out[i];
      end else if (ext_en[i]) begin
        level[i] = ext_val[i];
      end else begin
        level[i] = 1'b1;
      end
    end
  end
endmodule

// file: tb/test_quasi_bidir_port_altfn.sv
`timescale 1ns/1ps

module test_quasi_bidir_port_altfn;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                            ref_clk, rst_n;
  quasi_port_pkg::latch_write_type p1_wr, p2_wr, p3_wr;
  logic [7:0]                      p1_lv, p2_lv, p3_lv;   // resolved pin levels
  logic [7:0]                      p1_xen, p3_xen, p1_xv, p3_xv; // board drivers
  quasi_port_pkg::pin_drive_type   p1_pins, p2_pins, p3_pins;
  logic [7:0]                      p1_rd, p2_rd, p3_rd, addr_hi;
  logic                            addr_en, wr_n, rd_n, t2_o, s1_o, s0_o, strap_n;
  logic [11:0]                     core_in;                // peripheral inputs
  logic                            fetch_ext;
  int                              err_total, num_checks;

  // ----------------------------------------------------------------
  // clock, board and device
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  pin_board_model m1 (.pins(p1_pins), .ext_en(p1_xen), .ext_val(p1_xv), .level(p1_lv));
  pin_board_model m2 (.pins(p2_pins), .ext_en(8'h00), .ext_val(8'h00), .level(p2_lv));
  pin_board_model m3 (.pins(p3_pins), .ext_en(p3_xen), .ext_val(p3_xv), .level(p3_lv));
  quasi_bidir_port_altfn #(.STRONG_CYC(2)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .p1_wr(p1_wr), .p2_wr(p2_wr), .p3_wr(p3_wr),
    .p1_pin_in(p1_lv), .p2_pin_in(p2_lv), .p3_pin_in(p3_lv),
    .p1_pins(p1_pins), .p2_pins(p2_pins), .p3_pins(p3_pins),
    .p1_rd(p1_rd), .p2_rd(p2_rd), .p3_rd(p3_rd), .addr_en(addr_en), .addr_hi(addr_hi),
    .wr_strobe_n(wr_n), .rd_strobe_n(rd_n), .timer2_out(t2_o), .serial1_out(s1_o), .serial0_out(s0_o),
    .timer2_ext_io(core_in[0]), .timer2_trigger_in(core_in[1]), .serial1_in(core_in[2]),
    .serial0_in(core_in[3]), .ext_irq_0(core_in[4]), .ext_irq_1(core_in[5]),
    .ext_irq_2_rise(core_in[6]), .ext_irq_3_fall(core_in[7]), .ext_irq_4_rise(core_in[8]),
    .ext_irq_5_fall(core_in[9]), .timer0_count_in(core_in[10]), .timer1_count_in(core_in[11]),
    .program_source_sel_n(strap_n), .fetch_external_q(fetch_ext));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  // one comparison, four-state exact
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // step edges, then look after the edge has settled
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // reset held six cycles with a chosen strap level
  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    rst_n   <= 1'b0;
    strap_n <= s;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(5);   // strap taken on the third edge after release
  endtask
  // one-cycle store into a latch, port picked by number
  task automatic store(input int p, input logic [7:0] d);
    @(posedge ref_clk);
    if (p == 1) p1_wr <= '{1'b1, d};
    else if (p == 2) p2_wr <= '{1'b1, d};
    else p3_wr <= '{1'b1, d};
    @(posedge ref_clk);
    p1_wr.wr <= 1'b0;
    p2_wr.wr <= 1'b0;
    p3_wr.wr <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset state of all three ports and the strap
  task automatic t_reset;
    chk("p1_pins", 24'hff00ff, p1_pins);
    chk("p2_pins", 24'hff00ff, p2_pins);
    chk("p3_pins", 24'hff00ff, p3_pins);
    chk("p3_rd", 24'hff, p3_rd);
    chk("p2_rd", 24'hff, p2_rd);
    chk("fetch_ext", 24'h1, fetch_ext);
    $display("test reset done");
  endtask
  // zero store holds a pull-down, one store gives a short strong high
  task automatic t_latch;
    store(3, 8'h00);
    tick(1);
    chk("p3 zero", 24'h00ff00, p3_pins);
    tick(3);
    chk("p3 zero held", 24'h00ff00, p3_pins);
    store(3, 8'hff);
    tick(1);
    chk("p3 strong a", 24'hffff00, p3_pins);
    tick(1);
    chk("p3 strong b", 24'hffff00, p3_pins);
    tick(1);
    chk("p3 weak", 24'hff00ff, p3_pins);
    $display("test latch done");
  endtask
  // upper address byte on port 2, then back to latch contents
  task automatic t_addr;
    @(posedge ref_clk);
    addr_hi <= 8'ha5;
    addr_en <= 1'b1;
    tick(2);
    chk("p2 addr", 24'ha5ff00, p2_pins);
    @(posedge ref_clk);
    addr_en <= 1'b0;
    tick(2);
    chk("p2 back", 24'hff5aa5, p2_pins);
    tick(2);
    chk("p2 weak", 24'hff00ff, p2_pins);
    $display("test address done");
  endtask
  // alternate outputs, and a zero latch overriding one
  task automatic t_alt;
    @(posedge ref_clk);
    {wr_n, rd_n, t2_o, s1_o, s0_o} <= 5'h00;
    tick(2);
    chk("p3 out", 24'h3d, p3_pins.out);
    chk("p1 out", 24'hf6, p1_pins.out);
    @(posedge ref_clk);
    {wr_n, rd_n, t2_o, s1_o, s0_o} <= 5'h1f;
    store(1, 8'hf3);
    tick(2);
    chk("p1 latch wins", 24'hf3, p1_pins.out);
    store(1, 8'hff);
    tick(3);
    $display("test alternate done");
  endtask
  // board drives pins low then lets go; count edge pulses
  task automatic t_inputs;
    int f3, f5, r2, r4;
    f3 = 0;
    f5 = 0;
    r2 = 0;
    r4 = 0;
    @(posedge ref_clk);
    {p1_xen, p1_xv, p3_xen, p3_xv} <= 32'hff00ff00;
    repeat (6) begin
      tick(1);
      f3 += core_in[7];
      f5 += core_in[9];
      r2 += core_in[6];
      r4 += core_in[8];
    end
    chk("p1_rd", 24'h00, p1_rd);
    chk("p3_rd", 24'h00, p3_rd);
    chk("core_in", 24'h000, core_in);
    @(posedge ref_clk);
    p1_xen <= 8'h00;
    p3_xen <= 8'h00;
    repeat (6) begin
      tick(1);
      r2 += core_in[6];
      r4 += core_in[8];
    end
    chk("fall pulses", 24'h11, {f3[3:0], f5[3:0]});
    chk("rise pulses", 24'h11, {r2[3:0], r4[3:0]});
    chk("core_in hi", 24'h0c3f, core_in);
    $display("test inputs done");
  endtask
  // strap high after a fresh reset selects internal code
  task automatic t_strap;
    do_reset(1'b1);
    chk("fetch_ext", 24'h0, fetch_ext);
    $display("test strap done");
  endtask

  // ----------------------------------------------------------------
  // verdict, the one place the run ends
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence; inputs all set at time zero
  initial begin
    err_total = 0;
    num_checks = 0;
    {rst_n, p1_wr, p2_wr, p3_wr, addr_en, addr_hi} = '0;
    {wr_n, rd_n, t2_o, s1_o, s0_o, strap_n} = 6'h3e;
    {p1_xen, p1_xv, p3_xen, p3_xv} = '0;
    do_reset(1'b0);
    t_reset();
    t_latch();
    t_addr();
    t_alt();
    t_inputs();
    t_strap();
    final_report();
  end

  // watchdog, far beyond the roughly seventy cycles the tests need
  initial begin
    #20000;
    err_total++;
    final_report();
  end
endmodule
